// file: test_video_dual_splitter_regs.sv
// self-checking bench of the splitter register bank over axi4-lite
// assumes vdsp_regs, its package and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end \
end

module test_video_dual_splitter_regs;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
    logic [31:0] rexp;
    logic [1:0] resp;
  } vdsp_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic splitter_enable, splitter_soft_reset;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata_got;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_got, rresp_got;
  vdsp_pkg::vdsp_beat_t vid_beat;
  vdsp_pkg::vdsp_size_t active_size;
  vdsp_pkg::vdsp_seg_t active_seg;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  // plain register rows: address, data, strobes, read-back, response
  vdsp_row_t rows [9] = '{
    '{12'h020, 32'h0780_0438, 4'hf, 32'h0780_0438, 2'h0},
    '{12'h020, 32'h0000_00ab, 4'h1, 32'h0780_04ab, 2'h0},
    '{12'h100, 32'h0002_0404, 4'hf, 32'h0002_0404, 2'h0},
    '{12'h100, 32'h0001_0404, 4'hf, 32'h0001_0404, 2'h0},
    '{12'h00c, 32'hffff_ffff, 4'hf, 32'h0000_0001, 2'h0},
    '{12'h00c, 32'h0000_0000, 4'hf, 32'h0000_0000, 2'h0},
    '{12'h008, 32'hffff_ffff, 4'hf, 32'h0000_0000, 2'h0},
    '{12'h004, 32'h1234_5678, 4'hf, 32'h0000_0000, 2'h2},
    '{12'h000, 32'h0000_0001, 4'hf, 32'h0000_0001, 2'h0}};

  vdsp_regs DUT (.*);

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // hang guard: the whole run needs only a couple of hundred cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // readies are sampled at the rising edge where the handshake lands
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) ta = 1'b1;
      if (s_axi_wready) tw = 1'b1;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!(ta && tw));
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      tb = s_axi_bvalid;
      bresp_got = s_axi_bresp;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] r);
    logic t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t = s_axi_arready;
    end while (!t);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      t = s_axi_rvalid;
      rdata_got = s_axi_rdata;
      rresp_got = s_axi_rresp;
    end while (!t);
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, rdata_got)
    `CHK("rresp", r, rresp_got)
  endtask

  // stream beats; the caller idles the stream afterwards
  task automatic beats(input int n, input logic u, input logic l);
    for (int i = 0; i < n; i++) begin
      vid_beat <= '{1'b1, 1'b1, u && i == 0, l && i == n - 1};
      @(posedge aclk);
    end
  endtask

  task automatic err_case(input logic [31:0] e);
    vid_beat <= '0;
    repeat (4) @(posedge aclk);
    rchk(12'h008, e, 2'h0);
  endtask

  // soft reset pulse: flags must drop while it is held
  task automatic srst();
    wr(12'h000, 32'h8000_0003, 4'hf);
    `CHK("soft_reset", 1'b1, splitter_soft_reset)
    rchk(12'h008, 32'h0, 2'h0);
    `CHK("irq", 1'b0, irq)
    wr(12'h000, 32'h3, 4'hf);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_wstrb,
     s_axi_bready, s_axi_arvalid, s_axi_araddr, s_axi_rready} = '0;
    vid_beat = '0;
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata, rows[i].strb);
      `CHK("bresp", rows[i].resp, bresp_got)
      rchk(rows[i].addr, rows[i].rexp, rows[i].resp);
    end
    do_reset();
    rchk(12'h000, 32'h0000_0002, 2'h0);
    rchk(12'h008, 32'h0000_0000, 2'h0);
    rchk(12'h00c, 32'h0000_0000, 2'h0);
    rchk(12'h020, 32'h0870_0f00, 2'h0);
    rchk(12'h100, 32'h0001_0101, 2'h0);
    // small frame of width 4, height 2; beats ignored while disabled
    wr(12'h000, 32'h2, 4'hf);
    wr(12'h020, 32'h0004_0002, 4'hf);
    beats(2, 1'b1, 1'b1);
    err_case(32'h0);
    wr(12'h000, 32'h3, 4'hf);
    `CHK("active_size", 32'h0004_0002, active_size)
    `CHK("enable", 1'b1, splitter_enable)
    beats(2, 1'b1, 1'b1);
    err_case(32'h1);
    `CHK("irq masked", 1'b0, irq)
    wr(12'h00c, 32'h1, 4'hf);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    wr(12'h008, 32'h1, 4'h1);
    rchk(12'h008, 32'h0, 2'h0);
    `CHK("irq cleared", 1'b0, irq)
    srst();
    beats(4, 1'b1, 1'b0);
    err_case(32'h2);
    srst();
    beats(4, 1'b1, 1'b1);
    beats(1, 1'b1, 1'b0);
    err_case(32'h4);
    srst();
    beats(4, 1'b1, 1'b1);
    beats(4, 1'b0, 1'b1);
    beats(1, 1'b0, 1'b0);
    err_case(32'h8);
    srst();
    wrap_up();
  end
endmodule
`default_nettype wire

// file: vdsp_defs.svh
// offsets, field positions, reset values and bus codes of the splitter
// register bank; assumes inclusion by bare name from each design file
`ifndef VDSP_DEFS_SVH
`define VDSP_DEFS_SVH

// register byte offsets (12-bit address space)
`define VDSP_OFS_CTRL 12'h000
`define VDSP_OFS_ERR 12'h008
`define VDSP_OFS_IRQ 12'h00c
`define VDSP_OFS_SIZE 12'h020
`define VDSP_OFS_SEG 12'h100

// splitter_control field positions
`define VDSP_CTRL_EN 0
`define VDSP_CTRL_UPD 1
`define VDSP_CTRL_SRST 31

// error_interrupt_mask field position
`define VDSP_IRQ_EN 0

// error flag positions
`define VDSP_ERR_EOL_EARLY 0
`define VDSP_ERR_EOL_LATE 1
`define VDSP_ERR_SOF_EARLY 2
`define VDSP_ERR_SOF_LATE 3

// image size field positions
`define VDSP_SIZE_HEIGHT_LSB 0
`define VDSP_SIZE_WIDTH_LSB 16

// segment config field positions
`define VDSP_SEG_IN_SPC_LSB 0
`define VDSP_SEG_OUT_SPC_LSB 8
`define VDSP_SEG_COUNT_LSB 16
`define VDSP_SEG_OVERLAP_LSB 24

// reset values
`define VDSP_RST_CTRL 32'h0000_0002
`define VDSP_RST_ERR 4'h0
`define VDSP_RST_IRQ 1'h0
`define VDSP_RST_SIZE 32'h0870_0f00
`define VDSP_RST_SEG 32'h0001_0101

// axi4-lite response codes
`define VDSP_RESP_OKAY 2'h0
`define VDSP_RESP_SLVERR 2'h2

`endif

// file: vdsp_frame_check.sv
// frame checker: watches the splitter input stream and reports start of
// frame and end of line arriving early or late against the active size
// assumes the stream runs on aclk; beats count as samples of one line
`timescale 1ns/100ps
`default_nettype none
`include "vdsp_defs.svh"

module vdsp_frame_check (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic clear,
  input wire vdsp_pkg::vdsp_size_t size,
  // observed stream
  input wire vdsp_pkg::vdsp_beat_t beat,
  // one-cycle error events
  output vdsp_pkg::vdsp_err_t err
);

  logic [15:0] pix_ff;
  logic [15:0] line_ff;
  logic in_frame_ff;
  vdsp_pkg::vdsp_err_t err_ff;
  logic [15:0] nxt_pix;
  logic [15:0] nxt_line;
  logic nxt_in_frame;
  vdsp_pkg::vdsp_err_t nxt_err;
  logic take;
  logic [15:0] pos;
  logic at_last;

  // position tracking; beats before the first start of frame are ignored
  always_comb begin
    take = beat.tvalid & beat.tready & run;
    pos = beat.tuser ? 16'h0000 : pix_ff;
    at_last = (pos == size.width - 16'h0001);
    nxt_pix = pix_ff;
    nxt_line = line_ff;
    nxt_in_frame = in_frame_ff;
    nxt_err = '0;
    if (clear) begin
      nxt_pix = 16'h0000;
      nxt_line = 16'h0000;
      nxt_in_frame = 1'b0;
    end else if (take) begin
      if (beat.tuser) begin
        // a new frame before all lines arrived
        nxt_err.sof_early = in_frame_ff & (line_ff < size.height); // [RULE_03]
        nxt_line = 16'h0000;
        nxt_in_frame = 1'b1;
      end else begin
        // frame already complete but no start of frame came
        nxt_err.sof_late = in_frame_ff & (line_ff >= size.height); // [RULE_03]
      end
      if (beat.tuser | in_frame_ff) begin
        nxt_err.eol_early = beat.tlast & ~at_last; // [RULE_03]
        nxt_err.eol_late = at_last & ~beat.tlast; // [RULE_03]
        if (beat.tlast) begin
          nxt_pix = 16'h0000;
          nxt_line = (beat.tuser ? 16'h0000 : line_ff) + 16'h0001;
        end else begin
          // keeps counting past the width so late is flagged only once
          nxt_pix = pos + 16'h0001;
        end
      end
    end
  end

  // counter and event registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_ff <= 16'h0000;
      line_ff <= 16'h0000;
      in_frame_ff <= 1'b0;
      err_ff <= '0;
    end else begin
      pix_ff <= nxt_pix;
      line_ff <= nxt_line;
      in_frame_ff <= nxt_in_frame;
      err_ff <= nxt_err;
    end
  end

  assign err = err_ff;

endmodule
`default_nettype wire

// file: vdsp_pkg.sv
// types shared by the splitter register bank and its frame checker
// assumes vdsp_defs.svh is compiled alongside
package vdsp_pkg;

  // one beat of the splitter input stream, as seen by the checker
  typedef struct packed {
    logic tvalid;
    logic tready;
    logic tuser;
    logic tlast;
  } vdsp_beat_t;

  // error events, bit order matches splitter_error_flags
  typedef struct packed {
    logic sof_late;
    logic sof_early;
    logic eol_late;
    logic eol_early;
  } vdsp_err_t;

  // input image size, layout matches input_image_size
  typedef struct packed {
    logic [15:0] width;
    logic [15:0] height;
  } vdsp_size_t;

  // segment setup, layout matches segment_config
  typedef struct packed {
    logic [7:0] overlap;
    logic [7:0] segments;
    logic [7:0] out_spc;
    logic [7:0] in_spc;
  } vdsp_seg_t;

endpackage

// file: vdsp_regs.sv
// register bank of the video dual splitter behind an axi4-lite slave,
// with sticky error flags, interrupt and the active configuration copy
// assumes one clock aclk for bus and stream, synchronous low reset
//
// How it works
// [RULE_01] control bit 0 enables, bit 1 requests update, bit 31 soft resets
// [RULE_02] software writes 2 before programming and 3 when finished
// [RULE_03] error flags: eol early, eol late, sof early, sof late in bits 0-3
// [RULE_04] interrupt only while enable bit 0 is set; that bit resets low
// [RULE_05] image size: height bits 15-0, width 31-16, reset 0x0870_0f00
// [RULE_06] in uhd60 split mode software writes a quarter of the width
// [RULE_07] segment config: input spc, output spc, segment count bytes 0-2
// [RULE_08] software keeps overlap byte 31-24 at zero
// [RULE_09] software loads 0x020404 for uhd60 split, 0x10404 otherwise
// [RULE_10] error flags stick until written with one; soft reset clears all
`timescale 1ns/100ps
`default_nettype none
`include "vdsp_defs.svh"

module vdsp_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // observed splitter input stream
  input wire vdsp_pkg::vdsp_beat_t vid_beat,
  // configuration to the splitter datapath
  output logic splitter_enable,
  output logic splitter_soft_reset,
  output vdsp_pkg::vdsp_size_t active_size,
  output vdsp_pkg::vdsp_seg_t active_seg,
  // interrupt
  output logic irq
);

  // word-aligned address match, used by both write and read decode
  function automatic logic vdsp_hit(input logic [11:0] addr,
                                    input logic [11:0] ofs);
    vdsp_hit = (addr[11:2] == ofs[11:2]);
  endfunction

  // true when an address falls on one of the five registers
  function automatic logic vdsp_mapped(input logic [11:0] addr);
    vdsp_mapped = vdsp_hit(addr, `VDSP_OFS_CTRL) |
                  vdsp_hit(addr, `VDSP_OFS_ERR) |
                  vdsp_hit(addr, `VDSP_OFS_IRQ) |
                  vdsp_hit(addr, `VDSP_OFS_SIZE) |
                  vdsp_hit(addr, `VDSP_OFS_SEG);
  endfunction

  // byte-lane merge of new write data into an old register value
  function automatic logic [31:0] vdsp_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    vdsp_merge = res;
  endfunction

  // ---- write channel state
  logic aw_hold_ff;
  logic [11:0] aw_addr_ff;
  logic w_hold_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic nxt_aw_hold;
  logic [11:0] nxt_aw_addr;
  logic nxt_w_hold;
  logic [31:0] nxt_w_data;
  logic [3:0] nxt_w_strb;
  logic nxt_bvalid;
  logic [1:0] nxt_bresp;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // ---- read channel state
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;
  logic ar_take;

  // ---- register state
  logic [31:0] ctrl_ff;
  logic [3:0] err_ff;
  logic irq_en_ff;
  logic [31:0] size_ff;
  logic [31:0] seg_ff;
  vdsp_pkg::vdsp_size_t act_size_ff;
  vdsp_pkg::vdsp_seg_t act_seg_ff;
  logic irq_ff;
  logic [31:0] nxt_ctrl;
  logic [3:0] nxt_err;
  logic nxt_irq_en;
  logic [31:0] nxt_size;
  logic [31:0] nxt_seg;
  vdsp_pkg::vdsp_size_t nxt_act_size;
  vdsp_pkg::vdsp_seg_t nxt_act_seg;
  logic nxt_irq;
  logic [31:0] err_wmask;
  vdsp_pkg::vdsp_err_t chk_err;
  logic srst;

  // handshake readies: one write and one read in flight at a time
  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;

  // write channels: address and data are caught in either order, the
  // register is written when both are present, response one cycle later
  always_comb begin
    aw_take = s_axi_awvalid & s_axi_awready;
    w_take = s_axi_wvalid & s_axi_wready;
    wr_addr = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
    wr_data = w_hold_ff ? w_data_ff : s_axi_wdata;
    wr_strb = w_hold_ff ? w_strb_ff : s_axi_wstrb;
    do_write = (aw_hold_ff | aw_take) & (w_hold_ff | w_take);
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (bvalid_ff & s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      // unmapped addresses are answered with slverr and change nothing
      nxt_bresp = vdsp_mapped(wr_addr) ? `VDSP_RESP_OKAY
                                       : `VDSP_RESP_SLVERR;
    end else begin
      if (aw_take) begin
        nxt_aw_hold = 1'b1;
        nxt_aw_addr = s_axi_awaddr;
      end
      if (w_take) begin
        nxt_w_hold = 1'b1;
        nxt_w_data = s_axi_wdata;
        nxt_w_strb = s_axi_wstrb;
      end
    end
  end

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `VDSP_RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff <= nxt_w_hold;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // read channel: data registered one cycle after the address is taken
  always_comb begin
    ar_take = s_axi_arvalid & s_axi_arready;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff & s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `VDSP_RESP_OKAY;
      // reserved bits of the error and mask registers read as zero; control returns all 32 bits as written
      if (vdsp_hit(s_axi_araddr, `VDSP_OFS_CTRL)) begin
        nxt_rdata = ctrl_ff;
      end else if (vdsp_hit(s_axi_araddr, `VDSP_OFS_ERR)) begin
        nxt_rdata = {28'h000_0000, err_ff};
      end else if (vdsp_hit(s_axi_araddr, `VDSP_OFS_IRQ)) begin
        nxt_rdata = {31'h0000_0000, irq_en_ff};
      end else if (vdsp_hit(s_axi_araddr, `VDSP_OFS_SIZE)) begin
        nxt_rdata = size_ff;
      end else if (vdsp_hit(s_axi_araddr, `VDSP_OFS_SEG)) begin
        nxt_rdata = seg_ff;
      end else begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = `VDSP_RESP_SLVERR;
      end
    end
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `VDSP_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // soft reset is a level held while control bit 31 stays set
  assign srst = ctrl_ff[`VDSP_CTRL_SRST]; // [RULE_01]

  // frame checker feeding the error flags
  vdsp_frame_check u_check (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl_ff[`VDSP_CTRL_EN]),
    .clear(srst),
    .size(act_size_ff),
    .beat(vid_beat),
    .err(chk_err)
  );

  // register file next values
  always_comb begin
    err_wmask = vdsp_merge(32'h0000_0000, wr_data, wr_strb);
    nxt_ctrl = ctrl_ff;
    nxt_irq_en = irq_en_ff;
    nxt_size = size_ff;
    nxt_seg = seg_ff;
    nxt_err = err_ff;
    if (do_write & vdsp_hit(wr_addr, `VDSP_OFS_CTRL)) begin
      nxt_ctrl = vdsp_merge(ctrl_ff, wr_data, wr_strb); // [RULE_01]
    end
    if (do_write & vdsp_hit(wr_addr, `VDSP_OFS_IRQ) & wr_strb[0]) begin
      nxt_irq_en = wr_data[`VDSP_IRQ_EN]; // [RULE_04]
    end
    if (do_write & vdsp_hit(wr_addr, `VDSP_OFS_SIZE)) begin
      nxt_size = vdsp_merge(size_ff, wr_data, wr_strb); // [RULE_05]
    end
    if (do_write & vdsp_hit(wr_addr, `VDSP_OFS_SEG)) begin
      // overlap byte is stored as written; the datapath ignores it
      nxt_seg = vdsp_merge(seg_ff, wr_data, wr_strb); // [RULE_07]
    end
    // write one clears; a new event in the same cycle wins
    if (do_write & vdsp_hit(wr_addr, `VDSP_OFS_ERR)) begin
      nxt_err = err_ff & ~err_wmask[3:0]; // [RULE_10]
    end
    nxt_err = nxt_err | chk_err; // [RULE_03]
    if (srst) begin
      nxt_err = `VDSP_RST_ERR; // [RULE_10]
    end
  end

  // active copy: tracks the programmed values while disabled, and while
  // enabled reloads only on a control write carrying the update bit, so
  // the datapath never sees a half-programmed size
  always_comb begin
    nxt_act_size = act_size_ff;
    nxt_act_seg = act_seg_ff;
    if (~nxt_ctrl[`VDSP_CTRL_EN] |
        (do_write & vdsp_hit(wr_addr, `VDSP_OFS_CTRL) &
         nxt_ctrl[`VDSP_CTRL_UPD])) begin // [RULE_01]
      nxt_act_size = nxt_size;
      nxt_act_seg = nxt_seg;
    end
  end

  // level interrupt gated by the single enable bit
  always_comb begin
    nxt_irq = irq_en_ff & (|err_ff); // [RULE_04]
  end

  // register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `VDSP_RST_CTRL;
      err_ff <= `VDSP_RST_ERR;
      irq_en_ff <= `VDSP_RST_IRQ; // [RULE_04]
      size_ff <= `VDSP_RST_SIZE; // [RULE_05]
      seg_ff <= `VDSP_RST_SEG;
      act_size_ff <= `VDSP_RST_SIZE;
      act_seg_ff <= `VDSP_RST_SEG;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      err_ff <= nxt_err;
      irq_en_ff <= nxt_irq_en;
      size_ff <= nxt_size;
      seg_ff <= nxt_seg;
      act_size_ff <= nxt_act_size;
      act_seg_ff <= nxt_act_seg;
      irq_ff <= nxt_irq;
    end
  end

  // outputs, all from flip-flops except the readies
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign splitter_enable = ctrl_ff[`VDSP_CTRL_EN];
  assign splitter_soft_reset = srst;
  assign active_size = act_size_ff;
  assign active_seg = act_seg_ff;
  assign irq = irq_ff;

endmodule
`default_nettype wire

// file: vdsp_regs_chk.sv
// checker for the splitter register bank, seeing only its top ports
// assumes the bench offers write address and data at the same edge
`timescale 1ns/100ps
`default_nettype none

module vdsp_regs_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  // outputs under watch
  input wire logic splitter_enable,
  input wire logic splitter_soft_reset,
  input wire vdsp_pkg::vdsp_size_t active_size,
  input wire vdsp_pkg::vdsp_seg_t active_seg,
  input wire logic irq
);
  logic wr_go;
  logic mapped;
  logic irq_en_ff;
  logic nxt_irq_en;

  // a write lands when both halves are taken at one edge
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_wready;
  assign mapped = s_axi_awaddr[11:2] inside {10'h000, 10'h002, 10'h003,
                                             10'h008, 10'h040};

  // mirror of the interrupt enable bit, so gating can be judged
  always_comb begin
    nxt_irq_en = irq_en_ff;
    if (wr_go && s_axi_awaddr[11:2] == 10'h003 && s_axi_wstrb[0])
      nxt_irq_en = s_axi_wdata[0];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_en_ff <= 1'b0;
    else
      irq_en_ff <= nxt_irq_en;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_size_reset: assert property ($rose(aresetn) |->
    active_size == 32'h0870_0f00) else $error("size reset value wrong");
  chk_seg_reset: assert property ($rose(aresetn) |->
    active_seg == 32'h0001_0101) else $error("segment reset value wrong");
  chk_ctrl_reset: assert property ($rose(aresetn) |->
    !irq && !splitter_enable) else $error("control reset value wrong");
  chk_enable_write: assert property (
    wr_go && s_axi_awaddr[11:2] == 10'h000 && s_axi_wstrb[0] |=>
    splitter_enable == $past(s_axi_wdata[0])) else $error("enable bit");
  chk_srst_write: assert property (
    wr_go && s_axi_awaddr[11:2] == 10'h000 && s_axi_wstrb[3] |=>
    splitter_soft_reset == $past(s_axi_wdata[31])) else $error("srst bit");
  chk_size_copy: assert property (
    wr_go && s_axi_awaddr[11:2] == 10'h008 && s_axi_wstrb == 4'hf &&
    !splitter_enable |=> active_size == $past(s_axi_wdata))
    else $error("size copy wrong");
  chk_irq_gate: assert property (irq |-> $past(irq_en_ff))
    else $error("interrupt while disabled");
  chk_srst_clear: assert property (
    splitter_soft_reset [*4] |-> !irq) else $error("irq in soft reset");
  chk_write_resp: assert property (wr_go |=> s_axi_bvalid &&
    s_axi_bresp == ($past(mapped) ? 2'h0 : 2'h2))
    else $error("write response wrong");
endmodule

bind vdsp_regs vdsp_regs_chk u_chk (.*);
`default_nettype wire
